// [design/cmt_defs.svh]
// constants of the can mode sequencer: offsets, fields, resets, timing
// How it works
// RULE1 - global stop to reset within 3 clocks
// RULE2 - global reset to stop within 3 clocks
// RULE3 - global reset to test within 3 clocks
// RULE4 - global reset to operating within 3 clocks
// RULE5 - global test to reset within 3 clocks
// RULE6 - global test to operating within 3 clocks
// RULE7 - global operating to reset within 3 clocks
// RULE8 - global operating to test within 2 frames
// RULE9 - channel stop to reset within 3 clocks
// RULE10 - channel reset to stop within 3 clocks
// RULE11 - channel reset to halt within 3 bits
// RULE12 - channel reset to communication within 2 bits
// RULE13 - channel halt to reset within 3 clocks
// RULE14 - channel halt to communication within 3 bits
// RULE15 - channel communication to reset within 3 clocks
// RULE16 - channel communication to halt within 2 frames
// RULE17 - fifo config writable only in global reset
// RULE18 - software bounds every mode poll by timeout
// RULE19 - software configures each channel separately
// RULE20 - status shows mode only after completion
// RULE21 - new request replaces pending target safely
`ifndef CMT_DEFS_SVH
`define CMT_DEFS_SVH

// register byte offsets
`define CMT_A_GCTRL 8'h00
`define CMT_A_GSTAT 8'h04
`define CMT_A_BITLEN 8'h08
`define CMT_A_CH_BASE 8'h10
`define CMT_A_FIFO_BASE 8'h40
`define CMT_STRIDE 8'h08
`define CMT_A_SECOND 8'h04

// mode codes as software sees them
`define CMT_M_RUN 2'h0
`define CMT_M_RST 2'h1
`define CMT_M_HOLD 2'h2
`define CMT_M_STOP 2'h3

// status bit positions
`define CMT_ST_PEND 2
`define CMT_ST_DONE 3
`define CMT_ST_BAD 4
`define CMT_ST_LOCK 5

// fifo configuration write masks and reset values
`define CMT_LO_MASK 32'h0000F301
`define CMT_HI_MASK 32'h00000300
`define CMT_LO_RST 32'h00000000
`define CMT_HI_RST 32'h00000000

// timing: clocks per bit at reset, bits per frame, waits in bits
`define CMT_BITLEN_RST 16'h0014
`define CMT_FRAME_BITS 16'h0087
`define CMT_HALT_BITS 16'h0002
`define CMT_COMM_BITS 16'h0001

`endif

// [design/cmt_pkg.sv]
// types of the can mode sequencer
`default_nettype none
package cmt_pkg;
    // global mode states, one-hot
    typedef enum logic [3:0] {
        CMT_G_STOP = 4'h1,
        CMT_G_RST = 4'h2,
        CMT_G_TEST = 4'h4,
        CMT_G_OPER = 4'h8
    } cmt_glb_e;
    // channel mode states, one-hot
    typedef enum logic [3:0] {
        CMT_C_STOP = 4'h1,
        CMT_C_RST = 4'h2,
        CMT_C_HALT = 4'h4,
        CMT_C_COMM = 4'h8
    } cmt_chn_e;
    // two-bit mode code seen by software
    typedef logic [1:0] cmt_mode_t;
endpackage
`default_nettype wire

// [design/cmt_wait_timer.sv]
// bit-time wait counter, one instance in each of the mode state machines
`default_nettype none
module cmt_wait_timer (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // control
    input wire logic i_clear,
    input wire logic i_tick,
    input wire logic [15:0] i_limit,
    // result
    output logic o_expired
);
    logic [15:0] count_q;

    // counts bit ticks since the last clear, saturating
    always_ff @(posedge i_sys_clk) begin
        if (i_rst || i_clear) begin
            count_q <= 16'h0000;
        end else if (i_tick && (count_q != 16'hFFFF)) begin
            count_q <= count_q + 16'h0001;
        end
    end

    assign o_expired = (count_q >= i_limit);
endmodule
`default_nettype wire

// [design/cmt_chan_fsm.sv]
// per-channel mode state machine of the can mode sequencer
`include "cmt_defs.svh"
`default_nettype none
module cmt_chan_fsm #(
    parameter logic [15:0] FRAME_BITS = `CMT_FRAME_BITS
) (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // accepted request from the register side
    input wire logic i_req,
    input wire logic i_cancel,
    input wire logic [1:0] i_tgt,
    // global mode and bus side
    input wire logic i_glb_stop,
    input wire logic i_glb_rst,
    input wire logic i_bit_tick,
    input wire logic i_bus_idle,
    // status
    output logic [1:0] o_mode,
    output logic o_pend
);
    cmt_pkg::cmt_chn_e state_q;
    cmt_pkg::cmt_mode_t tgt_q;
    logic [15:0] limit;
    logic expired;
    logic done;

    // wait bound and completion test of the pending move
    always_comb begin
        limit = `CMT_HALT_BITS;
        done = 1'b1; // stop and reset moves finish next clock [RULE9] [RULE10] [RULE13] [RULE15]
        case (state_q)
            cmt_pkg::CMT_C_RST: begin
                if (tgt_q == `CMT_M_RUN) begin
                    limit = `CMT_COMM_BITS;
                    done = expired; // [RULE12]
                end else if (tgt_q == `CMT_M_HOLD) begin
                    done = expired; // [RULE11]
                end
            end
            cmt_pkg::CMT_C_HALT: begin
                if (tgt_q == `CMT_M_RUN) begin
                    done = expired; // [RULE14]
                end
            end
            cmt_pkg::CMT_C_COMM: begin
                if (tgt_q == `CMT_M_HOLD) begin
                    limit = 16'(2 * FRAME_BITS);
                    done = i_bus_idle || expired; // [RULE16]
                end
            end
            default: ;
        endcase
    end

    cmt_wait_timer u_wait (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_clear(i_req),
        .i_tick(i_bit_tick),
        .i_limit(limit),
        .o_expired(expired)
    );

    // mode state, pending target and visible mode
    always_ff @(posedge i_sys_clk) begin
        if (i_rst || i_glb_stop) begin
            state_q <= cmt_pkg::CMT_C_STOP;
            o_mode <= `CMT_M_STOP;
            tgt_q <= `CMT_M_STOP;
            o_pend <= 1'b0;
        end else if (i_glb_rst && (state_q == cmt_pkg::CMT_C_HALT || state_q == cmt_pkg::CMT_C_COMM)) begin
            state_q <= cmt_pkg::CMT_C_RST;
            o_mode <= `CMT_M_RST;
            o_pend <= 1'b0;
        end else if (i_cancel) begin
            o_pend <= 1'b0;
        end else if (i_req) begin
            tgt_q <= i_tgt; // [RULE21]
            o_pend <= 1'b1;
        end else if (o_pend && done) begin
            o_pend <= 1'b0;
            o_mode <= tgt_q; // [RULE20]
            case (tgt_q)
                `CMT_M_RUN: state_q <= cmt_pkg::CMT_C_COMM;
                `CMT_M_RST: state_q <= cmt_pkg::CMT_C_RST;
                `CMT_M_HOLD: state_q <= cmt_pkg::CMT_C_HALT;
                default: state_q <= cmt_pkg::CMT_C_STOP;
            endcase
        end
    end
endmodule
`default_nettype wire

// [design/cmt_mode_seq.sv]
// top of the can mode sequencer: registers, global mode, channels, fifo lock
`include "cmt_defs.svh"
`default_nettype none
module cmt_mode_seq #(
    parameter int NUM_CH = 2,
    parameter int NUM_FIFO = 2,
    parameter logic [15:0] FRAME_BITS = `CMT_FRAME_BITS
) (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // register port
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    // bus side, one bit per channel
    input wire logic [NUM_CH-1:0] i_ch_bus_idle,
    // mode status
    output wire logic [1:0] o_glb_mode,
    output wire logic [2*NUM_CH-1:0] o_ch_mode,
    // fifo configuration words
    output wire logic [32*NUM_FIFO-1:0] o_fifo_cfg_lo,
    output wire logic [32*NUM_FIFO-1:0] o_fifo_cfg_hi
);

    // ****************************************
    // declarations
    // ****************************************

    // global mode machine
    cmt_pkg::cmt_glb_e glb_q;
    cmt_pkg::cmt_mode_t glb_mode_q;
    cmt_pkg::cmt_mode_t gtgt_q;
    logic gpend_q;
    logic gdone;
    logic gexp;
    logic [15:0] glimit;

    // bit time base
    logic [15:0] bitlen_q;
    logic [15:0] bcnt_q;
    logic bit_tick;

    // status flags
    logic done_q;
    logic bad_q;
    logic lock_q;
    logic done_ev;
    logic bad_ev;
    logic lock_ev;

    // write decode
    logic gctrl_wr;
    logic gstat_wr;
    logic bitlen_wr;
    cmt_pkg::cmt_mode_t req;
    logic glb_ok;
    logic in_rst;
    logic glb_run;

    // channel signals
    logic [NUM_CH-1:0] ch_wr;
    logic [NUM_CH-1:0] ch_req;
    logic [NUM_CH-1:0] ch_cancel;
    logic [NUM_CH-1:0] ch_bad;
    logic [NUM_CH-1:0] ch_pend;
    logic [NUM_CH-1:0] ch_quiet;
    logic [2*NUM_CH-1:0] ch_mode;

    // fifo words
    logic [NUM_FIFO-1:0] lo_wr;
    logic [NUM_FIFO-1:0] hi_wr;
    logic [31:0] fifo_lo_q [NUM_FIFO];
    logic [31:0] fifo_hi_q [NUM_FIFO];

    // read mux
    logic [31:0] rd_val;

    // ****************************************
    // mode legality
    // ****************************************

    // stop leads only to reset, reset leads anywhere, test and run never to stop
    function automatic logic legal(input logic [1:0] cur, input logic [1:0] tgt);
        logic ok;

        ok = 1'b0;
        case (cur)
            `CMT_M_STOP: ok = (tgt == `CMT_M_RST);
            `CMT_M_RST: ok = (tgt != `CMT_M_RST);
            default: ok = (tgt != `CMT_M_STOP) && (tgt != cur);
        endcase
        return ok;
    endfunction

    // ****************************************
    // register write decode
    // ****************************************

    assign req = i_wdata[1:0];
    assign gctrl_wr = i_wr && (i_addr == `CMT_A_GCTRL);
    assign gstat_wr = i_wr && (i_addr == `CMT_A_GSTAT);
    assign bitlen_wr = i_wr && (i_addr == `CMT_A_BITLEN);

    assign glb_ok = legal(glb_mode_q, req);

    assign in_rst = (glb_q == cmt_pkg::CMT_G_RST);
    assign glb_run = (glb_q == cmt_pkg::CMT_G_OPER) || (glb_q == cmt_pkg::CMT_G_TEST);

    // ****************************************
    // bit time base
    // ****************************************

    // clocks per can bit, software programmable
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            bitlen_q <= `CMT_BITLEN_RST;
        end else if (bitlen_wr) begin
            bitlen_q <= i_wdata[15:0];
        end
    end

    // one tick per bit time; zero or one means every clock
    assign bit_tick = (bcnt_q >= bitlen_q);

    always_ff @(posedge i_sys_clk) begin
        if (i_rst || bit_tick) begin
            bcnt_q <= 16'h0001;
        end else begin
            bcnt_q <= bcnt_q + 16'h0001;
        end
    end

    // ****************************************
    // global mode state machine
    // ****************************************

    // operating to test waits for quiet channels, bounded by two frames
    assign glimit = 16'(2 * FRAME_BITS);

    always_comb begin
        gdone = 1'b1; // other global moves finish next clock [RULE1] [RULE2] [RULE3] [RULE4]
        case (glb_q)
            cmt_pkg::CMT_G_OPER: begin
                if (gtgt_q == `CMT_M_HOLD) begin
                    gdone = (&ch_quiet) || gexp; // [RULE8]
                end
            end
            cmt_pkg::CMT_G_TEST: gdone = 1'b1; // [RULE5] [RULE6]
            default: ;
        endcase
    end

    cmt_wait_timer u_gwait (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_clear(gctrl_wr),
        .i_tick(bit_tick),
        .i_limit(glimit),
        .o_expired(gexp)
    );

    // global state, pending target and visible mode
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            glb_q <= cmt_pkg::CMT_G_STOP;
            glb_mode_q <= `CMT_M_STOP;
            gtgt_q <= `CMT_M_STOP;
            gpend_q <= 1'b0;
        end else if (gctrl_wr) begin
            if (req == glb_mode_q) begin
                gpend_q <= 1'b0; // asking for the present mode drops the pending move
            end else if (glb_ok) begin
                gtgt_q <= req; // [RULE21]
                gpend_q <= 1'b1;
            end
        end else if (gpend_q && gdone) begin
            gpend_q <= 1'b0;
            glb_mode_q <= gtgt_q; // [RULE20] [RULE7]
            case (gtgt_q)
                `CMT_M_RUN: glb_q <= cmt_pkg::CMT_G_OPER;
                `CMT_M_RST: glb_q <= cmt_pkg::CMT_G_RST;
                `CMT_M_HOLD: glb_q <= cmt_pkg::CMT_G_TEST;
                default: glb_q <= cmt_pkg::CMT_G_STOP;
            endcase
        end
    end

    // global mode out
    assign o_glb_mode = glb_mode_q;

    // ****************************************
    // sticky status flags
    // ****************************************

    // flag events
    assign done_ev = gpend_q && gdone && !gctrl_wr;
    assign bad_ev = (gctrl_wr && (req != glb_mode_q) && !glb_ok) || (|ch_bad);
    assign lock_ev = (|(lo_wr | hi_wr)) && !in_rst;

    // set wins over a write-one-to-clear in the same cycle
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            done_q <= 1'b0;
            bad_q <= 1'b0;
            lock_q <= 1'b0;
        end else begin
            done_q <= done_ev || (done_q && !(gstat_wr && i_wdata[`CMT_ST_DONE]));
            bad_q <= bad_ev || (bad_q && !(gstat_wr && i_wdata[`CMT_ST_BAD]));
            lock_q <= lock_ev || (lock_q && !(gstat_wr && i_wdata[`CMT_ST_LOCK]));
        end
    end

    // ****************************************
    // channels
    // ****************************************

    genvar gc;
    generate
        for (gc = 0; gc < NUM_CH; gc++) begin : g_ch
            logic [1:0] cur;
            logic ok;

            assign cur = ch_mode[2*gc+:2];

            assign ch_wr[gc] = i_wr && (i_addr == `CMT_A_CH_BASE + `CMT_STRIDE * 8'(gc));
            // halt and communication need a running global mode
            assign ok = legal(cur, req) && (glb_run || req == `CMT_M_STOP || req == `CMT_M_RST);

            assign ch_cancel[gc] = ch_wr[gc] && (req == cur);
            assign ch_req[gc] = ch_wr[gc] && (req != cur) && ok;
            assign ch_bad[gc] = ch_wr[gc] && (req != cur) && !ok;
            assign ch_quiet[gc] = i_ch_bus_idle[gc] || (cur != `CMT_M_RUN);

            // channel machine
            cmt_chan_fsm #(
                .FRAME_BITS(FRAME_BITS)
            ) u_ch (
                .i_sys_clk(i_sys_clk),
                .i_rst(i_rst),
                .i_req(ch_req[gc]),
                .i_cancel(ch_cancel[gc]),
                .i_tgt(req),
                .i_glb_stop(glb_q == cmt_pkg::CMT_G_STOP),
                .i_glb_rst(in_rst),
                .i_bit_tick(bit_tick),
                .i_bus_idle(i_ch_bus_idle[gc]),
                .o_mode(ch_mode[2*gc+:2]),
                .o_pend(ch_pend[gc])
            );
        end
    endgenerate

    // channel modes out
    assign o_ch_mode = ch_mode;

    // ****************************************
    // fifo configuration, locked outside global reset
    // ****************************************

    genvar gf;
    generate
        for (gf = 0; gf < NUM_FIFO; gf++) begin : g_fifo
            // word strobes
            assign lo_wr[gf] = i_wr && (i_addr == `CMT_A_FIFO_BASE + `CMT_STRIDE * 8'(gf));
            assign hi_wr[gf] = i_wr && (i_addr == `CMT_A_FIFO_BASE + `CMT_STRIDE * 8'(gf) + `CMT_A_SECOND);

            // enable, direction, fill threshold and timing select
            always_ff @(posedge i_sys_clk) begin
                if (i_rst) begin
                    fifo_lo_q[gf] <= `CMT_LO_RST;
                end else if (lo_wr[gf] && in_rst) begin
                    fifo_lo_q[gf] <= i_wdata & `CMT_LO_MASK; // [RULE17]
                end
            end

            // linked transmit buffer select
            always_ff @(posedge i_sys_clk) begin
                if (i_rst) begin
                    fifo_hi_q[gf] <= `CMT_HI_RST;
                end else if (hi_wr[gf] && in_rst) begin
                    fifo_hi_q[gf] <= i_wdata & `CMT_HI_MASK; // [RULE17]
                end
            end

            assign o_fifo_cfg_lo[32*gf+:32] = fifo_lo_q[gf];
            assign o_fifo_cfg_hi[32*gf+:32] = fifo_hi_q[gf];
        end
    endgenerate

    // ****************************************
    // register read
    // ****************************************

    // unmapped addresses and control words of channels read as zero
    always_comb begin
        rd_val = 32'h00000000;
        case (i_addr)
            `CMT_A_GCTRL: rd_val = {30'h00000000, gtgt_q};
            `CMT_A_GSTAT: begin
                rd_val[1:0] = glb_mode_q; // [RULE20]
                rd_val[`CMT_ST_PEND] = gpend_q;
                rd_val[`CMT_ST_DONE] = done_q;
                rd_val[`CMT_ST_BAD] = bad_q;
                rd_val[`CMT_ST_LOCK] = lock_q;
            end
            `CMT_A_BITLEN: rd_val = {16'h0000, bitlen_q};
            default: ;
        endcase

        for (int c = 0; c < NUM_CH; c++) begin
            if (i_addr == `CMT_A_CH_BASE + `CMT_STRIDE * 8'(c) + `CMT_A_SECOND) begin
                rd_val = {29'h00000000, ch_pend[c], ch_mode[2*c+:2]}; // [RULE20]
            end
        end

        for (int f = 0; f < NUM_FIFO; f++) begin
            if (i_addr == `CMT_A_FIFO_BASE + `CMT_STRIDE * 8'(f)) begin
                rd_val = fifo_lo_q[f];
            end
            if (i_addr == `CMT_A_FIFO_BASE + `CMT_STRIDE * 8'(f) + `CMT_A_SECOND) begin
                rd_val = fifo_hi_q[f];
            end
        end
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_rdata <= 32'h00000000;
        end else if (i_rd) begin
            o_rdata <= rd_val;
        end else begin
            o_rdata <= 32'h00000000;
        end
    end

endmodule
`default_nettype wire

// [tb/cmt_mode_seq_monitor.sv]
// assertions on the ports of the can mode sequencer
`include "cmt_defs.svh"
`default_nettype none
module cmt_mode_seq_monitor #(
    parameter int NUM_CH = 2,
    parameter int NUM_FIFO = 2,
    parameter logic [15:0] FRAME_BITS = `CMT_FRAME_BITS
) (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // register port
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [31:0] o_rdata,
    // bus side and status
    input wire logic [NUM_CH-1:0] i_ch_bus_idle,
    input wire logic [1:0] o_glb_mode,
    input wire logic [2*NUM_CH-1:0] o_ch_mode,
    input wire logic [32*NUM_FIFO-1:0] o_fifo_cfg_lo,
    input wire logic [32*NUM_FIFO-1:0] o_fifo_cfg_hi
);
    timeunit 1ns;
    timeprecision 1ns;
    // *****
    // bounds, assuming one bit per clock
    // *****
    localparam int FRM_WAIT = 2 * FRAME_BITS + 3;
    // short names for requests and modes
    wire logic gw = i_wr && i_addr == `CMT_A_GCTRL;
    wire logic cw = i_wr && i_addr == `CMT_A_CH_BASE;
    wire logic [1:0] gm = o_glb_mode;
    wire logic [1:0] cm = o_ch_mode[1:0];
    wire logic [1:0] wd = i_wdata[1:0];
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (i_rst);
    // global moves
    a_glb_stop_rst: assert property (gw && gm == 2'h3 && wd == 2'h1 |-> ##[1:3] gm == 2'h1)
        else $error("global stop to reset too slow");
    a_glb_rst_stop: assert property (gw && gm == 2'h1 && wd == 2'h3 |-> ##[1:3] gm == 2'h3)
        else $error("global reset to stop too slow");
    a_glb_rst_test: assert property (gw && gm == 2'h1 && wd == 2'h2 |-> ##[1:3] gm == 2'h2)
        else $error("global reset to test too slow");
    a_glb_rst_oper: assert property (gw && gm == 2'h1 && wd == 2'h0 |-> ##[1:3] gm == 2'h0)
        else $error("global reset to operating too slow");
    a_glb_back_rst: assert property (gw && !gm[0] && wd == 2'h1 |-> ##[1:3] gm == 2'h1)
        else $error("global return to reset too slow");
    a_glb_oper_test: assert property (gw && gm == 2'h0 && wd == 2'h2 |-> ##[1:FRM_WAIT] gm == 2'h2)
        else $error("global operating to test too slow");
    // channel zero moves
    a_ch_to_rst: assert property (cw && gm != 2'h3 && cm != 2'h1 && wd == 2'h1
        |-> ##[1:3] cm == 2'h1)
        else $error("channel return to reset too slow");
    a_ch_rst_stop: assert property (cw && cm == 2'h1 && wd == 2'h3 |-> ##[1:3] cm == 2'h3)
        else $error("channel reset to stop too slow");
    a_ch_rst_comm: assert property (cw && gm == 2'h0 && cm == 2'h1 && wd == 2'h0 |-> ##[1:4] cm == 2'h0)
        else $error("channel reset to communication too slow");
    a_ch_leave_rst: assert property (cw && gm == 2'h0 && cm == 2'h1 && wd == 2'h2 |-> ##[1:5] !cm[0])
        else $error("channel reset to halt too slow");
    a_ch_comm_halt: assert property (cw && gm == 2'h0 && cm == 2'h0 && wd == 2'h2
        |-> ##[1:FRM_WAIT] (cm == 2'h2 || cw))
        else $error("channel communication to halt too slow");
    // fifo lock and status
    a_fifo_lock: assert property (i_wr && i_addr == `CMT_A_FIFO_BASE && gm != 2'h1
        |=> $stable(o_fifo_cfg_lo[31:0]))
        else $error("fifo word changed outside global reset");
    a_stat_mirror: assert property (i_rd && i_addr == `CMT_A_GSTAT |=> o_rdata[1:0] == $past(gm))
        else $error("global status does not show the mode");
    // main scenarios reached
    c_oper_test: cover property (gw && gm == 2'h0 && wd == 2'h2);
    c_comm_halt: cover property (cw && cm == 2'h0 && wd == 2'h2);
    c_fifo_load: cover property (i_wr && i_addr == `CMT_A_FIFO_BASE && gm == 2'h1);
endmodule
bind cmt_mode_seq cmt_mode_seq_monitor #(.NUM_CH(NUM_CH), .NUM_FIFO(NUM_FIFO), .FRAME_BITS(FRAME_BITS)) u_mon (
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_ch_bus_idle(i_ch_bus_idle), .o_glb_mode(o_glb_mode), .o_ch_mode(o_ch_mode),
    .o_fifo_cfg_lo(o_fifo_cfg_lo), .o_fifo_cfg_hi(o_fifo_cfg_hi));
`default_nettype wire

// [tb/cmt_bus_node.sv]
// far-side can nodes: one bus idle flag per channel, whole frames only
`default_nettype none
module cmt_bus_node #(
    parameter int NUM_CH = 2
) (
    // clock and traffic request
    input wire logic i_sys_clk,
    input wire logic [NUM_CH-1:0] i_busy,
    // bus idle flags
    output logic [NUM_CH-1:0] o_bus_idle
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] left_q [NUM_CH] = '{default: 3'h0};
    // a started frame runs to its end, frames follow back to back while busy
    always @(posedge i_sys_clk) begin
        for (int c = 0; c < NUM_CH; c++) begin
            if (left_q[c] != 3'h0) left_q[c] <= left_q[c] - 3'h1;
            else if (i_busy[c]) left_q[c] <= 3'h7;
        end
    end
    // idle only between frames with no traffic waiting
    always_comb begin
        for (int c = 0; c < NUM_CH; c++) o_bus_idle[c] = left_q[c] == 3'h0 && !i_busy[c];
    end
endmodule
`default_nettype wire

// [tb/cmt_mode_seq_bench.sv]
// self-checking bench of the can mode sequencer
`include "cmt_defs.svh"
`default_nettype none
module cmt_mode_seq_bench;
    timeunit 1ns;
    timeprecision 1ns;
    // *****
    // stimulus and observed signals
    // *****
    localparam logic [15:0] FRM = 16'h0004;
    localparam logic [1:0] GSEQ [8] = '{2'h3, 2'h1, 2'h2, 2'h1, 2'h0, 2'h1, 2'h2, 2'h0};
    localparam logic [1:0] CSEQ [9] = '{2'h1, 2'h3, 2'h1, 2'h2, 2'h1, 2'h0, 2'h1, 2'h2, 2'h0};
    localparam int CBND [9] = '{3, 3, 3, 3, 3, 2, 3, 3, 3};
    logic i_sys_clk = 1'b0;
    logic i_rst = 1'b1;
    logic [7:0] i_addr = 8'h00;
    logic [31:0] i_wdata = 32'h0;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [1:0] busy = 2'h0;
    wire logic [1:0] idle;
    wire logic [31:0] o_rdata;
    wire logic [1:0] o_glb_mode;
    wire logic [3:0] o_ch_mode;
    wire logic [127:0] cfg;
    int err_count = 0;
    int checks = 0;
    int seed = 6120;
    logic rd_seen = 1'b0;
    logic [31:0] exp_q [$];
    logic [31:0] msk_q [$];
    always #25 i_sys_clk = ~i_sys_clk;
    // design and far side
    cmt_mode_seq #(.NUM_CH(2), .NUM_FIFO(2), .FRAME_BITS(FRM)) dut (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_ch_bus_idle(idle),
        .o_glb_mode(o_glb_mode), .o_ch_mode(o_ch_mode), .o_fifo_cfg_lo(cfg[63:0]), .o_fifo_cfg_hi(cfg[127:64]));
    cmt_bus_node #(.NUM_CH(2)) u_node (.i_sys_clk(i_sys_clk), .i_busy(busy), .o_bus_idle(idle));
    // *****
    // tasks
    // *****
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_sys_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_sys_clk);
        i_wr <= 1'b0;
    endtask
    // a read notes its masked expectation for the watcher
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        exp_q.push_back(e);
        msk_q.push_back(m);
        @(posedge i_sys_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_sys_clk);
        i_rd <= 1'b0;
    endtask
    // bounded wait for a mode: sel 0 is global, 1 and 2 the channels
    task automatic poll(input int sel, input logic [1:0] e, input int n);
        logic [1:0] m;
        for (int i = 0; i <= n; i++) begin
            @(negedge i_sys_clk);
            m = sel == 0 ? o_glb_mode : o_ch_mode[2*sel-2 +: 2];
            if (m === e) break;
        end
        check("mode", {30'h0, m}, {30'h0, e});
        if (m !== e) give_verdict();
    endtask
    // watcher: read data stand in the cycle after the strobe
    always @(negedge i_sys_clk) begin
        if (rd_seen) begin
            check("rdata", o_rdata & msk_q[0], exp_q[0]);
            void'(exp_q.pop_front());
            void'(msk_q.pop_front());
        end
        rd_seen = i_rd;
    end
    // *****
    // main sequence
    // *****
    initial begin
        logic [31:0] d;
        logic [7:0] ca;
        repeat (5) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        rd(`CMT_A_GSTAT, 32'h3, 32'h3F);
        rd(`CMT_A_BITLEN, {16'h0, `CMT_BITLEN_RST}, 32'hFFFF);
        wr(`CMT_A_BITLEN, 32'h1);
        wr(`CMT_A_FIFO_BASE, 32'hFFFFFFFF);
        wr(`CMT_A_GCTRL, 32'h2);
        poll(0, 2'h3, 3);
        rd(`CMT_A_FIFO_BASE, 32'h0, 32'hFFFFFFFF);
        rd(`CMT_A_GSTAT, 32'h33, 32'h3F);
        wr(`CMT_A_GSTAT, 32'h38);
        wr(`CMT_A_GCTRL, 32'h1);
        poll(0, 2'h1, 3);
        // fifo words load in global reset
        for (int k = 0; k < 2; k++) begin
            d = $random(seed);
            wr(`CMT_A_FIFO_BASE + 8'(8 * k), d);
            rd(`CMT_A_FIFO_BASE + 8'(8 * k), d & `CMT_LO_MASK, 32'hFFFFFFFF);
            check("lo", cfg[32*k+:32], d & `CMT_LO_MASK);
            wr(`CMT_A_FIFO_BASE + `CMT_A_SECOND + 8'(8 * k), ~d);
            rd(`CMT_A_FIFO_BASE + `CMT_A_SECOND + 8'(8 * k), ~d & `CMT_HI_MASK, 32'hFFFFFFFF);
            check("hi", cfg[64+32*k+:32], ~d & `CMT_HI_MASK);
        end
        foreach (GSEQ[i]) begin
            wr(`CMT_A_GCTRL, {30'h0, GSEQ[i]});
            poll(0, GSEQ[i], 3);
        end
        // every channel walked on its own
        for (int c = 0; c < 2; c++) begin
            ca = `CMT_A_CH_BASE + 8'(8 * c);
            foreach (CSEQ[i]) begin
                wr(ca, {30'h0, CSEQ[i]});
                poll(c + 1, CSEQ[i], CBND[i]);
            end
        end
        // halt request cancelled by a request for the present mode
        busy <= 2'h1;
        wr(`CMT_A_CH_BASE, 32'h2);
        wr(`CMT_A_CH_BASE, 32'h0);
        repeat (2 * FRM + 3) @(posedge i_sys_clk);
        rd(`CMT_A_CH_BASE + `CMT_A_SECOND, 32'h0, 32'h7);
        wr(`CMT_A_CH_BASE, 32'h2);
        poll(1, 2'h2, 2 * FRM + 1);
        wr(`CMT_A_CH_BASE, 32'h0);
        poll(1, 2'h0, 3);
        // pending target replaced in mid-wait
        wr(`CMT_A_CH_BASE, 32'h1);
        poll(1, 2'h1, 3);
        wr(`CMT_A_CH_BASE, 32'h2);
        wr(`CMT_A_CH_BASE, 32'h0);
        poll(1, 2'h0, 2);
        rd(`CMT_A_CH_BASE + `CMT_A_SECOND, 32'h0, 32'h7);
        wr(`CMT_A_GCTRL, 32'h2);
        poll(0, 2'h2, 2 * FRM + 1);
        busy <= 2'h0;
        rd(`CMT_A_GCTRL, 32'h2, 32'h3);
        wr(8'h80, 32'hFFFFFFFF);
        rd(8'h80, 32'h0, 32'hFFFFFFFF);
        repeat (3) @(posedge i_sys_clk);
        give_verdict();
    end
endmodule
`default_nettype wire
